/* sspc_board_model.sv */
// board circuitry on the pads: drives undriven pins or lets them float
// assumes pad outputs of sspc_top and a bench-chosen external drive
`timescale 1ns/1ps
module sspc_board_model
  import sspc_pkg::*;
(
  input wire logic clk,
  input wire logic [PIN_COUNT-1:0] pad_out,
  input wire logic [PIN_COUNT-1:0] pad_oe,
  input wire logic [PIN_COUNT-1:0] pad_pu,
  input wire logic [PIN_COUNT-1:0] ext_en,
  input wire logic [PIN_COUNT-1:0] ext_val,
  output logic [PIN_COUNT-1:0] pad_in
);
  // a floating pin wanders each cycle so a stale level cannot pass for a held one
  logic [PIN_COUNT-1:0] wander_q = 8'h55;
  always @(posedge clk) wander_q <= ~wander_q;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
    | (~pad_oe & ~ext_en & pad_pu) | (~pad_oe & ~ext_en & ~pad_pu & wander_q);
endmodule

/* sspc_in_sync.sv */
// three-stage synchroniser with agreement filter for the pad inputs
// assumes pad_in is asynchronous to clk
`timescale 1ns/1ps
module sspc_in_sync
  import sspc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [PIN_COUNT-1:0] pad_in,
  sspc_sync_if.src sync
);

  logic [PIN_COUNT-1:0] s1_q;
  logic [PIN_COUNT-1:0] s2_q;
  logic [PIN_COUNT-1:0] s3_q;
  logic [PIN_COUNT-1:0] lvl_q;

  // first stage is read only by the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= RST_SYNC;
      s2_q <= RST_SYNC;
      s3_q <= RST_SYNC;
    end else begin
      s1_q <= pad_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a level counts only once stages two and three agree
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lvl_q <= RST_SYNC;
    end else begin
      lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
    end
  end

  assign sync.lvl = lvl_q;

endmodule

/* sspc_pkg.sv */
// constants and types of the standby pin state control block
// assumes the system mode controller encodes its mode as sspc_mode_t
package sspc_pkg;

  localparam int PIN_COUNT = 8;

  // pins 0 and 3 carry an external interrupt, pin 6 is shared with the debug wire
  localparam logic [PIN_COUNT-1:0] EXTINT_PIN_MASK = 8'h09;
  localparam logic [PIN_COUNT-1:0] DEBUG_PIN_MASK = 8'h40;

  localparam logic [PIN_COUNT-1:0] RST_PAD_OUT = 8'h00;
  localparam logic [PIN_COUNT-1:0] RST_PAD_OE = 8'h00;
  localparam logic [PIN_COUNT-1:0] RST_PAD_PU = 8'h00;
  localparam logic [PIN_COUNT-1:0] RST_PAD_IE = 8'hFF;
  localparam logic [PIN_COUNT-1:0] RST_PORT_IN = 8'h00;
  localparam logic [PIN_COUNT-1:0] RST_SYNC = 8'h00;

  typedef enum logic [1:0] {
    SSPC_NORMAL = 2'h0,
    SSPC_SLEEP = 2'h1,
    SSPC_STOP = 2'h3,
    SSPC_WATCH = 2'h2
  } sspc_mode_t;

endpackage

/* sspc_sync_if.sv */
// synchronised pad levels passed from the input stage to the pin control
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface sspc_sync_if;
  import sspc_pkg::*;
  logic [PIN_COUNT-1:0] lvl;
  modport src (output lvl);
  modport dst (input lvl);
endinterface

/* sspc_top.sv */
// pin state control across run, sleep, stop, watch and reset
// assumes mode, select and request inputs are synchronous to clk
// Behaviour
// RL1: stop or watch with select low: outputs hold last state, input blocked.
// RL2: stop or watch with select high: outputs float, pull-up kept, input blocked.
// RL3: interrupt pins bypass input blocking while their interrupt request is enabled.
// RL4: during reset pins float, input buffer on, sampled input reaches nothing.
// RL5: debug wire pin floats without pull-up in standby with select high.
// RL6: normal and sleep: pins follow port or peripheral, no standby gating.
`timescale 1ns/1ps
module sspc_top
  import sspc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input sspc_mode_t mode,
  input wire logic standby_pin_level_select,
  input wire logic [PIN_COUNT-1:0] out_req,
  input wire logic [PIN_COUNT-1:0] oe_req,
  input wire logic [PIN_COUNT-1:0] pu_req,
  input wire logic [PIN_COUNT-1:0] extint_en,
  input wire logic [PIN_COUNT-1:0] pad_in,
  output logic [PIN_COUNT-1:0] pad_out,
  output logic [PIN_COUNT-1:0] pad_oe,
  output logic [PIN_COUNT-1:0] pad_pu,
  output logic [PIN_COUNT-1:0] pad_ie,
  output logic [PIN_COUNT-1:0] port_in,
  output logic [PIN_COUNT-1:0] extint_in
);

  sspc_sync_if sync_bus ();

  sspc_in_sync u_sync (
    .clk(clk),
    .rstn(rstn),
    .pad_in(pad_in),
    .sync(sync_bus.src)
  );

  logic standby;
  logic stby_hold;
  logic stby_float;

  always_comb begin
    unique case (mode)
      SSPC_NORMAL: standby = 1'b0;
      SSPC_SLEEP: standby = 1'b0;
      SSPC_STOP: standby = 1'b1;
      SSPC_WATCH: standby = 1'b1;
    endcase
  end

  assign stby_hold = standby && !standby_pin_level_select;
  assign stby_float = standby && standby_pin_level_select;

  logic [PIN_COUNT-1:0] pad_out_q;
  logic [PIN_COUNT-1:0] pad_oe_q;
  logic [PIN_COUNT-1:0] pad_pu_q;
  logic [PIN_COUNT-1:0] pad_ie_q;
  logic [PIN_COUNT-1:0] port_in_q;
  logic [PIN_COUNT-1:0] extint_in_q;

  logic [PIN_COUNT-1:0] pad_lvl;
  assign pad_lvl = sync_bus.lvl;

  genvar i;
  generate
    for (i = 0; i < PIN_COUNT; i++) begin : g_pin
      // pad data is frozen through both standby flavours and only matters in hold
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pad_out_q[i] <= RST_PAD_OUT[i];
        end else if (standby) begin
          pad_out_q[i] <= pad_out_q[i]; // see RL1
        end else begin
          pad_out_q[i] <= out_req[i]; // see RL6
        end
      end

      // output enable; reset floats every pin (see RL4)
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pad_oe_q[i] <= RST_PAD_OE[i];
        end else if (stby_hold) begin
          pad_oe_q[i] <= pad_oe_q[i]; // see RL1
        end else if (stby_float) begin
          pad_oe_q[i] <= 1'b0; // see RL2
        end else begin
          pad_oe_q[i] <= oe_req[i]; // see RL6
        end
      end

      // pull-up: hold freezes it, float keeps the request except on the debug wire pin
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pad_pu_q[i] <= RST_PAD_PU[i];
        end else if (stby_hold) begin
          pad_pu_q[i] <= pad_pu_q[i]; // see RL1
        end else if (stby_float) begin
          pad_pu_q[i] <= pu_req[i] && !DEBUG_PIN_MASK[i]; // see RL2 RL5
        end else begin
          pad_pu_q[i] <= pu_req[i]; // see RL6
        end
      end

      // input buffer: in standby only enabled interrupt pins stay open
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pad_ie_q[i] <= RST_PAD_IE[i]; // see RL4
        end else if (standby) begin
          pad_ie_q[i] <= EXTINT_PIN_MASK[i] && extint_en[i]; // see RL3
        end else begin
          pad_ie_q[i] <= 1'b1; // see RL6
        end
      end

      // port input: blocked reads as low rather than the last level, so no stale data leaks
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          port_in_q[i] <= RST_PORT_IN[i]; // see RL4
        end else if (standby) begin
          port_in_q[i] <= 1'b0; // see RL1 RL2
        end else begin
          port_in_q[i] <= pad_lvl[i]; // see RL6
        end
      end

      // interrupt input: gated by the enable only in standby, the edge detector gates it in run
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          extint_in_q[i] <= RST_PORT_IN[i]; // see RL4
        end else if (standby) begin
          extint_in_q[i] <= EXTINT_PIN_MASK[i] && extint_en[i] && pad_lvl[i]; // see RL3
        end else begin
          extint_in_q[i] <= EXTINT_PIN_MASK[i] && pad_lvl[i]; // see RL6
        end
      end
    end
  endgenerate

  assign pad_out = pad_out_q;
  assign pad_oe = pad_oe_q;
  assign pad_pu = pad_pu_q;
  assign pad_ie = pad_ie_q;
  assign port_in = port_in_q;
  assign extint_in = extint_in_q;

  // every output is one register deep, so each check looks one edge back;
  // $past(rstn) keeps the edge right after release from judging reset-time history
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_hold_drive: assert property ($past(rstn) && $past(stby_hold) |-> // see RL1
    pad_out == $past(pad_out) && pad_oe == $past(pad_oe))
    else $error("pad drive changed while held");

  chk_hold_pullup: assert property ($past(rstn) && $past(stby_hold) |-> // see RL1
    pad_pu == $past(pad_pu))
    else $error("pull-up changed while held");

  chk_float_oe: assert property ($past(rstn) && $past(stby_float) |-> // see RL2
    pad_oe == '0)
    else $error("pad driven in float standby");

  chk_float_pullup: assert property ($past(rstn) && $past(stby_float) |-> // see RL2
    pad_pu == ($past(pu_req) & ~DEBUG_PIN_MASK))
    else $error("pull-up not kept in float standby");

  chk_float_data: assert property ($past(rstn) && $past(stby_float) |-> // see RL2
    pad_out == $past(pad_out))
    else $error("pad data changed in float standby");

  chk_debug_no_pu: assert property ($past(rstn) && $past(stby_float) |-> // see RL5
    (pad_pu & DEBUG_PIN_MASK) == '0)
    else $error("debug pin pull-up in float standby");

  chk_ie_bypass: assert property ($past(rstn) && $past(standby) |-> // see RL3
    pad_ie == ($past(extint_en) & EXTINT_PIN_MASK))
    else $error("input buffer gating wrong in standby");

  chk_ie_closed: assert property ($past(rstn) && $past(standby) |-> // see RL3
    (pad_ie & ~EXTINT_PIN_MASK) == '0)
    else $error("plain pin input open in standby");

  chk_extint_pass: assert property ($past(rstn) && $past(standby) |-> // see RL3
    extint_in == ($past(pad_lvl) & $past(extint_en) & EXTINT_PIN_MASK))
    else $error("interrupt input not bypassed");

  chk_extint_pins: assert property ($past(rstn) |-> // see RL3
    (extint_in & ~EXTINT_PIN_MASK) == '0)
    else $error("interrupt input on a plain pin");

  chk_port_block: assert property ($past(rstn) && $past(standby) |-> // see RL1
    port_in == '0)
    else $error("port input not blocked in standby");

  chk_run_follow: assert property ($past(rstn) && !$past(standby) |-> // see RL6
    pad_out == $past(out_req) && pad_oe == $past(oe_req)
    && port_in == $past(pad_lvl) && pad_ie == '1)
    else $error("pin not following port in run");

  chk_run_pullup: assert property ($past(rstn) && !$past(standby) |-> // see RL6
    pad_pu == $past(pu_req))
    else $error("pull-up not following request in run");

  chk_run_extint: assert property ($past(rstn) && !$past(standby) |-> // see RL6
    extint_in == ($past(pad_lvl) & EXTINT_PIN_MASK))
    else $error("interrupt input not following pad in run");

  chk_reset_state: assert property (!$past(rstn) |-> // see RL4
    pad_oe == '0 && pad_ie == '1 && port_in == '0 && extint_in == '0)
    else $error("pin state wrong out of reset");

  chk_reset_drive: assert property (!$past(rstn) |-> // see RL4
    pad_out == RST_PAD_OUT && pad_pu == RST_PAD_PU)
    else $error("pad drive not at reset value");

  cov_stop_hold: cover property (mode == SSPC_STOP && !standby_pin_level_select ##1 standby);
  cov_watch_float: cover property (mode == SSPC_WATCH && standby_pin_level_select ##1 standby);
  cov_wake_irq: cover property (standby && (extint_in != '0));
  cov_resume: cover property (standby ##1 !standby);
  cov_debug_float: cover property (stby_float && (pu_req & DEBUG_PIN_MASK) != '0);

endmodule

/* tb.sv */
// self-checking bench of sspc_top with a board model on the pads
// assumes a 100 MHz clock and levels driven at the rising edge
`timescale 1ns/1ps
module tb
  import sspc_pkg::*;
;
  logic clk, rstn, sel;
  sspc_mode_t mode;
  logic [7:0] out_req, oe_req, pu_req, extint_en, pad_in, ext_en, ext_val;
  logic [7:0] pad_out, pad_oe, pad_pu, pad_ie, port_in, extint_in;
  int error_cnt = 0;
  int total_checks = 0;
  sspc_top dut (.clk(clk), .rstn(rstn), .mode(mode), .standby_pin_level_select(sel),
    .out_req(out_req), .oe_req(oe_req), .pu_req(pu_req), .extint_en(extint_en),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu),
    .pad_ie(pad_ie), .port_in(port_in), .extint_in(extint_in));
  sspc_board_model board (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu),
    .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("errors=%0d checks=%0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // reset mid-run while the pads still toggle: nothing may reach the port
  task t_reset;
    @(posedge clk);
    rstn <= 0;
    ext_en <= 8'h00;
    wt(2);
    chk(pad_oe, 8'h00);
    chk(pad_ie, 8'hFF);
    chk({port_in | extint_in}, 8'h00);
    @(posedge clk);
    rstn <= 1;
    ext_en <= 8'hFF;
  endtask
  task t_run(input sspc_mode_t m);
    @(posedge clk);
    mode <= m;
    {out_req, oe_req, pu_req, extint_en, ext_val} <= {8'hA5, 8'h0F, 8'h33, 8'h00, 8'hF0};
    wt(6);
    chk(pad_out, 8'hA5);
    chk(pad_oe, 8'h0F);
    chk(pad_pu, 8'h33);
    chk(pad_ie, 8'hFF);
    chk(port_in, 8'hF5);
    chk(extint_in, 8'hF5 & EXTINT_PIN_MASK);
  endtask
  // requests change once standby is in force; hold must ignore them
  task t_standby(input sspc_mode_t m, input logic s);
    @(posedge clk);
    mode <= SSPC_NORMAL;
    sel <= s;
    {out_req, oe_req, pu_req, extint_en, ext_val} <= {8'hC3, 8'hFF, 8'hFF, 8'h09, 8'h09};
    wt(6);
    @(posedge clk);
    mode <= m;
    wt(1);
    @(posedge clk);
    {out_req, oe_req} <= 16'h3C00;
    wt(6);
    chk(pad_out, 8'hC3);
    chk(pad_oe, s ? 8'h00 : 8'hFF);
    chk(pad_pu, s ? ~DEBUG_PIN_MASK : 8'hFF);
    chk(port_in, 8'h00);
    chk(pad_ie, 8'h09);
    chk(extint_in, s ? 8'h09 : 8'h01);
    @(posedge clk);
    extint_en <= 8'h01;
    wt(6);
    chk(pad_ie, 8'h01);
    chk(extint_in, 8'h01);
  endtask
  initial begin
    rstn = 0;
    sel = 0;
    mode = SSPC_NORMAL;
    {out_req, oe_req, pu_req, extint_en, ext_en, ext_val} = {32'h0, 8'hFF, 8'h5A};
    repeat (5) @(posedge clk);
    rstn <= 1;
    t_run(SSPC_NORMAL);
    t_run(SSPC_SLEEP);
    t_standby(SSPC_STOP, 0);
    t_standby(SSPC_WATCH, 0);
    t_standby(SSPC_STOP, 1);
    t_standby(SSPC_WATCH, 1);
    t_reset();
    t_run(SSPC_NORMAL);
    wrap_up();
  end
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
endmodule
